// [rtl/tsm_pkg.sv]
`default_nettype none
package tsm_pkg;
  typedef enum logic [1:0] {
    TSM_GMII = 2'h0,
    TSM_MII = 2'h1,
    TSM_RGMII = 2'h2
  } tsm_phy_t;
  typedef enum logic [1:0] {
    TSM_MD_IDLE = 2'h0,
    TSM_MD_SHIFT = 2'h1,
    TSM_MD_DONE = 2'h3
  } tsm_md_state_t;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int MAC_HZ_1G = 125000000;
  localparam int MAC_HZ_100 = 25000000;
  localparam int MAC_HZ_10 = 2500000;
  localparam int CLASS_HALF_NS = 62500;
  localparam int CLASS_CYC = CLASS_HALF_NS / CLK_NS;
  function automatic int tsm_half(input int hz);
    return (CLK_HZ / (2 * hz) < 1) ? 1 : CLK_HZ / (2 * hz);
  endfunction
  localparam logic [3:0] HALF_1G = 4'(tsm_half(MAC_HZ_1G));
  localparam logic [3:0] HALF_100 = 4'(tsm_half(MAC_HZ_100));
  localparam logic [3:0] HALF_10 = 4'(tsm_half(MAC_HZ_10));
  ////////////////////////////////////////////////////////////////////////////
  // speed select and in-band status
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1G = 2'h2;
  localparam int IB_LINK = 0;
  localparam int IB_SPD = 1;
  localparam int IB_DUP = 3;
  localparam int SYNC_W = 15;
  ////////////////////////////////////////////////////////////////////////////
  // management frame
  localparam logic [31:0] MD_PRE = 32'hFFFFFFFF;
  localparam logic [1:0] MD_SOF = 2'h1;
  localparam logic [1:0] MD_OP_RD = 2'h2;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [1:0] MD_TA_WR = 2'h2;
  localparam logic [6:0] MD_TA = 7'h2E;
  localparam logic [6:0] MD_DATA = 7'h30;
  localparam logic [6:0] MD_LAST = 7'h3F;
endpackage
`default_nettype wire

// [rtl/tsm_mgmt_if.sv]
`default_nettype none
interface tsm_mgmt_if;
  logic start;
  logic rd;
  logic [4:0] phy;
  logic [4:0] reg_a;
  logic [15:0] wdata;
  logic [5:0] div;
  logic busy;
  logic done;
  logic [15:0] rdata;
  modport ctl(output start, rd, phy, reg_a, wdata, div, input busy, done, rdata);
  modport eng(input start, rd, phy, reg_a, wdata, div, output busy, done, rdata);
endinterface
`default_nettype wire

// [rtl/tsm_mdio.sv]
`default_nettype none
module tsm_mdio
  import tsm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  tsm_mgmt_if.eng m,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_t
);
  tsm_md_state_t st;
  logic [5:0] cnt;
  logic [6:0] bits;
  logic [63:0] sh;
  logic [15:0] rd;
  logic op_rd;
  wire shifting = (st == TSM_MD_SHIFT);
  wire half = (cnt == m.div);
  wire rise = shifting & half & ~mdc;
  wire fall = shifting & half & mdc;
  wire [6:0] next_bits = bits + 7'h01;
  wire next_t = op_rd & (next_bits >= MD_TA);
  wire [1:0] op = m.rd ? MD_OP_RD : MD_OP_WR;
  wire [63:0] frame = {MD_PRE, MD_SOF, op, m.phy, m.reg_a, MD_TA_WR, m.wdata};
  //////////////////////////////////////////////////////////////////////////////
  // clause 22 frame shifter, mdc from clk divided by 2*(div+1)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 6'h00;
    end else begin
      cnt <= (half || !shifting) ? 6'h00 : cnt + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= TSM_MD_IDLE;
      mdc <= 1'h0;
      mdio_o <= 1'h1;
      mdio_t <= 1'h1;
      bits <= 7'h00;
      sh <= 64'h0;
      rd <= 16'h0000;
      op_rd <= 1'h0;
      m.busy <= 1'h0;
      m.done <= 1'h0;
      m.rdata <= 16'h0000;
    end else begin
      case (st)
        TSM_MD_IDLE: begin
          m.done <= 1'h0;
          if (m.start) begin
            sh <= frame;
            op_rd <= m.rd;
            bits <= 7'h00;
            m.busy <= 1'h1;
            mdio_o <= frame[63];
            mdio_t <= 1'h0;
            st <= TSM_MD_SHIFT;
          end
        end
        TSM_MD_SHIFT: begin
          if (half) begin
            mdc <= ~mdc;
          end
          if (rise && op_rd && bits >= MD_DATA) begin
            rd <= {rd[14:0], mdio_in};
          end
          if (fall && bits == MD_LAST) begin
            mdio_t <= 1'h1;
            st <= TSM_MD_DONE;
          end else if (fall) begin
            bits <= next_bits;
            sh <= {sh[62:0], 1'h0};
            mdio_o <= sh[62];
            mdio_t <= next_t;
          end
        end
        TSM_MD_DONE: begin
          m.busy <= 1'h0;
          m.done <= 1'h1;
          m.rdata <= rd;
          st <= TSM_MD_IDLE;
        end
        default: begin
          st <= TSM_MD_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  md_idle_release_a: assert property (
    @(posedge clk) disable iff (!arst_n) (st != TSM_MD_SHIFT) |-> mdio_t)
    else $error("mdio driven outside a frame");
  md_turnaround_a: assert property (
    @(posedge clk) disable iff (!arst_n) shifting && op_rd && bits >= MD_TA |-> mdio_t)
    else $error("mdio driven during read turnaround or data");
  md_read_done_c: cover property (@(posedge clk) disable iff (!arst_n) m.done && op_rd);
endmodule
`default_nettype wire

// [rtl/tsm_sideband.sv]
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - rgmii shared build exports zero-phase copy of the reference clock
// - rgmii shared build exports quarter-period delayed copy for clock forwarding
// - one general interrupt, only source is management transaction complete
// - avb build pulses receive timing interrupt after ptp packet capture
// - avb build pulses transmit timing interrupt after ptp packet sent
// - avb build pulses timer interrupt every 1/128 s of rtc time
// - avb build outputs rtc nanoseconds and seconds fields
// - avb build outputs 8 kHz class interval clock locked to rtc
// - avb build outputs 1722-format nanoseconds consistent with rtc
// - management pins active only when management option is built
// - mdc is clk divided by software-supplied divisor
// - mdio driven only while its tristate control is low
// - exactly one phy attachment, gmii, mii or rgmii, fixed at build
// - gmii: 8-bit tx and rx with enable/valid and error at 1g, 4-bit nibbles at 100m and 10m
// - mii: 4-bit tx on phy tx clock, 4-bit rx on phy rx clock
// - collision and carrier sense synchronised before use
// - rgmii: 4-bit data plus control, forwarded transmit clock
// - rgmii: output in-band link, speed and duplex status
// - mac clock rate: clk/2 at both 1g and 100m, clk/8 at 10m
// - whole block resets asynchronously while global reset low
////////////////////////////////////////////////////////////////////////////////
module tsm_sideband
  import tsm_pkg::*;
#(
  parameter tsm_phy_t PHY_MODE = TSM_RGMII,
  parameter bit HAS_SHARED = 1'h1,
  parameter bit HAS_AVB = 1'h1,
  parameter bit HAS_MGMT = 1'h1,
  parameter logic [29:0] SEC_NS = 30'h3B9ACA00,
  parameter logic [22:0] TIMER_NS = 23'h773594
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic glbl_rst_n,
  input wire logic [1:0] speed_sel,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_err,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  output logic [7:0] phy_txd,
  output logic phy_tx_en,
  output logic phy_tx_er,
  output logic phy_txc,
  input wire logic phy_tx_clk,
  input wire logic phy_rx_clk,
  input wire logic [7:0] phy_rxd,
  input wire logic phy_rx_dv,
  input wire logic phy_rx_er,
  input wire logic phy_col,
  input wire logic phy_crs,
  output logic col,
  output logic crs,
  output logic inband_link,
  output logic [1:0] inband_speed,
  output logic inband_duplex,
  output logic shared_tx_clock,
  output logic shared_tx_clock_quarter_phase,
  input wire logic mgmt_start,
  input wire logic mgmt_read,
  input wire logic [4:0] mgmt_phy,
  input wire logic [4:0] mgmt_reg,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [5:0] mgmt_div,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_busy,
  output logic mgmt_done,
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_t,
  input wire logic int_enable,
  input wire logic int_clear,
  output logic mac_int,
  input wire logic ptp_rx_event,
  input wire logic ptp_tx_event,
  output logic ptp_rx_int,
  output logic ptp_tx_int,
  output logic ptp_timer_int,
  output logic [29:0] rtc_nanosec,
  output logic [47:0] rtc_sec,
  output logic [31:0] rtc_nanosec_1722,
  output logic class_interval_clock
);
  //////////////////////////////////////////////////////////////////////////////
  // reset
  logic rst_q;
  always_ff @(posedge clk or negedge glbl_rst_n) begin
    if (!glbl_rst_n) begin
      rst_q <= 1'h1;
    end else begin
      rst_q <= rst;
    end
  end
  wire arst_n = glbl_rst_n & ~rst_q;
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic tclk_d;
  logic rclk_d;
  logic tclk;
  logic rclk;
  logic [7:0] rxd;
  logic rdv;
  logic rer;
  logic cols;
  logic crss;
  logic mdin;
  assign {tclk, rclk, rxd, rdv, rer, cols, crss, mdin} = s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      tclk_d <= 1'h0;
      rclk_d <= 1'h0;
    end else begin
      s1 <= {phy_tx_clk, phy_rx_clk, phy_rxd, phy_rx_dv, phy_rx_er, phy_col, phy_crs, mdio_i};
      s2 <= s1;
      tclk_d <= tclk;
      rclk_d <= rclk;
    end
  end
  wire tclk_rise = tclk & ~tclk_d;
  wire rclk_rise = rclk & ~rclk_d;
  wire rclk_fall = ~rclk & rclk_d;
  //////////////////////////////////////////////////////////////////////////////
  // attachment and mac clock rate
  wire is_rgmii = (PHY_MODE == TSM_RGMII);
  wire is_byte = (PHY_MODE == TSM_GMII) && (speed_sel == SPD_1G);
  wire is_nib = !is_rgmii && !is_byte;
  logic [3:0] hcnt;
  wire [3:0] hlim = (speed_sel == SPD_1G) ? HALF_1G : (speed_sel == SPD_100) ? HALF_100 : HALF_10;
  wire half_en = (hcnt >= hlim - 4'h1);
  wire tx_rise = half_en & ~phy_txc;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hcnt <= 4'h0;
      phy_txc <= 1'h0;
    end else begin
      hcnt <= half_en ? 4'h0 : hcnt + 4'h1;
      phy_txc <= is_nib ? 1'h0 : phy_txc ^ half_en;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // transmit
  logic [7:0] hold;
  logic hold_v;
  logic hold_er;
  logic [3:0] hi_nib;
  logic hi_er;
  logic tx_hi;
  wire tx_step = is_nib ? tclk_rise : is_byte ? tx_rise : half_en;
  wire take = tx_valid & tx_ready;
  wire lo_go = tx_step & ~tx_hi & ~(is_rgmii & phy_txc);
  wire hi_go = tx_step & tx_hi;
  wire send = lo_go & hold_v;
  wire next_hold_v = take | (hold_v & ~send);
  wire [7:0] lo_txd = is_byte ? hold : {4'h0, hold[3:0]};
  wire hi_en = is_rgmii ? ~hi_er : 1'h1;
  wire hi_txer = is_rgmii ? 1'h0 : hi_er;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= 8'h00;
      hold_v <= 1'h0;
      hold_er <= 1'h0;
      tx_ready <= 1'h0;
    end else begin
      hold_v <= next_hold_v;
      tx_ready <= ~next_hold_v;
      if (take) begin
        hold <= tx_data;
        hold_er <= tx_err;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phy_txd <= 8'h00;
      phy_tx_en <= 1'h0;
      phy_tx_er <= 1'h0;
      hi_nib <= 4'h0;
      hi_er <= 1'h0;
      tx_hi <= 1'h0;
    end else if (hi_go) begin
      phy_txd <= {4'h0, hi_nib};
      phy_tx_en <= hi_en;
      phy_tx_er <= hi_txer;
      tx_hi <= 1'h0;
    end else if (lo_go) begin
      phy_txd <= send ? lo_txd : 8'h00;
      phy_tx_en <= send;
      phy_tx_er <= send & hold_er & ~is_rgmii;
      tx_hi <= send & ~is_byte;
      hi_nib <= hold[7:4];
      hi_er <= hold_er;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // receive
  logic [3:0] rx_lo;
  logic rx_hi;
  logic ctl_r;
  wire byte_cap = is_byte & rclk_rise;
  wire nib_cap = is_nib & rclk_rise & rdv & rx_hi;
  wire rg_cap = is_rgmii & rclk_fall;
  wire lo_cap = (is_nib & rclk_rise & rdv & ~rx_hi) | (is_rgmii & rclk_rise);
  wire ib_cap = rg_cap & ~ctl_r & ~rdv;
  wire next_rx_hi = (is_nib & rclk_rise) ? rdv & ~rx_hi : rx_hi;
  wire [7:0] next_rx_data = is_byte ? rxd : {rxd[3:0], rx_lo};
  wire next_rx_valid = byte_cap ? rdv : nib_cap | (rg_cap & ctl_r);
  wire next_rx_err = byte_cap ? rdv & rer : nib_cap ? rer : rg_cap & (ctl_r ^ rdv);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= 8'h00;
      rx_valid <= 1'h0;
      rx_err <= 1'h0;
      rx_lo <= 4'h0;
      rx_hi <= 1'h0;
      ctl_r <= 1'h0;
    end else begin
      rx_valid <= next_rx_valid;
      rx_err <= next_rx_err;
      rx_hi <= next_rx_hi;
      if (byte_cap || nib_cap || rg_cap) begin
        rx_data <= next_rx_data;
      end
      if (lo_cap) begin
        rx_lo <= rxd[3:0];
        ctl_r <= rdv;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inband_link <= 1'h0;
      inband_speed <= 2'h0;
      inband_duplex <= 1'h0;
    end else if (ib_cap) begin
      inband_link <= rx_lo[IB_LINK];
      inband_speed <= rx_lo[IB_SPD +: 2];
      inband_duplex <= rx_lo[IB_DUP];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      col <= 1'h0;
      crs <= 1'h0;
    end else begin
      col <= cols;
      crs <= crss;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // shared transmit clocks
  logic [1:0] ph;
  wire [1:0] next_ph = ph + 2'h1;
  wire shared_on = HAS_SHARED & is_rgmii;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 2'h0;
      shared_tx_clock <= 1'h0;
      shared_tx_clock_quarter_phase <= 1'h0;
    end else begin
      ph <= next_ph;
      shared_tx_clock <= shared_on & next_ph[1];
      shared_tx_clock_quarter_phase <= shared_on & ~(next_ph[1] ^ next_ph[0]);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // management
  tsm_mgmt_if mi ();
  assign mi.start = HAS_MGMT & mgmt_start;
  assign mi.rd = mgmt_read;
  assign mi.phy = mgmt_phy;
  assign mi.reg_a = mgmt_reg;
  assign mi.wdata = mgmt_wdata;
  assign mi.div = mgmt_div;
  assign mgmt_rdata = mi.rdata;
  assign mgmt_busy = mi.busy;
  assign mgmt_done = mi.done;
  tsm_mdio u_mdio (
    .clk(clk),
    .arst_n(arst_n),
    .m(mi.eng),
    .mdio_in(mdin),
    .mdc(mdc),
    .mdio_o(mdio_o),
    .mdio_t(mdio_t)
  );
  //////////////////////////////////////////////////////////////////////////////
  // interrupts
  wire mac_set = HAS_MGMT & int_enable & mi.done;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_int <= 1'h0;
      ptp_rx_int <= 1'h0;
      ptp_tx_int <= 1'h0;
    end else begin
      mac_int <= mac_set | (mac_int & ~int_clear);
      ptp_rx_int <= HAS_AVB & ptp_rx_event;
      ptp_tx_int <= HAS_AVB & ptp_tx_event;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // real-time clock
  logic [22:0] tmr;
  logic [15:0] cls;
  wire ns_wrap = rtc_nanosec >= SEC_NS - 30'(CLK_NS);
  wire tmr_hit = tmr >= TIMER_NS - 23'(CLK_NS);
  wire cls_hit = cls >= 16'(CLASS_HALF_NS - CLK_NS);
  wire [29:0] ns_inc = rtc_nanosec + 30'(CLK_NS);
  wire [22:0] tmr_inc = tmr + 23'(CLK_NS);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_nanosec <= 30'h0;
      rtc_sec <= 48'h0;
      rtc_nanosec_1722 <= 32'h0;
      tmr <= 23'h0;
      ptp_timer_int <= 1'h0;
    end else if (HAS_AVB) begin
      rtc_nanosec <= ns_wrap ? ns_inc - SEC_NS : ns_inc;
      rtc_sec <= ns_wrap ? rtc_sec + 48'h1 : rtc_sec;
      rtc_nanosec_1722 <= rtc_nanosec_1722 + 32'(CLK_NS);
      tmr <= tmr_hit ? tmr_inc - TIMER_NS : tmr_inc;
      ptp_timer_int <= tmr_hit;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cls <= 16'h0;
      class_interval_clock <= 1'h0;
    end else if (HAS_AVB) begin
      cls <= cls_hit ? 16'h0 : cls + 16'(CLK_NS);
      class_interval_clock <= class_interval_clock ^ cls_hit;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  localparam int TIMER_CYC = int'(TIMER_NS) / CLK_NS;
  int tgap;
  int cgap;
  logic tseen;
  logic cseen;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgap <= 0;
      cgap <= 0;
      tseen <= 1'h0;
      cseen <= 1'h0;
    end else begin
      tgap <= ptp_timer_int ? 1 : tgap + 1;
      cgap <= cls_hit ? 1 : cgap + 1;
      tseen <= tseen | ptp_timer_int;
      cseen <= cseen | cls_hit;
    end
  end
  shared_period_a: assert property (
    $rose(shared_tx_clock) |=> !$rose(shared_tx_clock) [*3] ##1 $rose(shared_tx_clock))
    else $error("shared clock period not four cycles");
  quarter_lag_a: assert property (
    shared_tx_clock_quarter_phase == $past(shared_tx_clock))
    else $error("quarter phase clock not one quarter behind");
  mac_int_set_a: assert property (
    mi.done && int_enable && HAS_MGMT |=> mac_int)
    else $error("interrupt not raised on management completion");
  mac_int_hold_a: assert property (
    mac_int && !int_clear |=> mac_int)
    else $error("interrupt dropped without a clear");
  ptp_rx_pulse_a: assert property (
    HAS_AVB && ptp_rx_event |=> ptp_rx_int)
    else $error("receive timing interrupt missing");
  timer_gap_a: assert property (
    ptp_timer_int && tseen |-> tgap == TIMER_CYC)
    else $error("timer interrupt spacing wrong");
  class_gap_a: assert property (
    cls_hit && cseen |-> cgap == CLASS_CYC)
    else $error("class clock half period wrong");
  ns_step_a: assert property (
    HAS_AVB && rtc_nanosec < SEC_NS - 30'(CLK_NS) |=> rtc_nanosec == $past(ns_inc))
    else $error("rtc nanoseconds did not advance by one period");
  ns_1722_a: assert property (
    HAS_AVB |=> rtc_nanosec_1722 - $past(rtc_nanosec_1722) == 32'(CLK_NS))
    else $error("1722 nanoseconds out of step");
  col_sync_a: assert property (
    phy_col |-> ##3 col)
    else $error("collision not seen after synchroniser");
  timer_c: cover property (ptp_timer_int);
  rx_byte_c: cover property (rx_valid);
  tx_take_c: cover property (tx_valid && tx_ready);
  mgmt_done_c: cover property (mi.done);
endmodule
`default_nettype wire

// [verif/tsm_phy_model.sv]
`default_nettype none
module tsm_phy_model #(
  parameter logic [15:0] RD_VAL = 16'hC3A5
) (
  input wire logic clk,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_t,
  output logic mdio_i,
  output logic phy_tx_clk,
  output logic phy_rx_clk,
  output logic [7:0] phy_rxd,
  output logic phy_rx_dv,
  output logic phy_rx_er,
  output logic phy_col,
  output logic phy_crs
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_rise = 0;
  logic rd_bit = 1'h1;
  initial begin
    phy_tx_clk = 1'h0;
    phy_rx_clk = 1'h0;
    phy_rxd = 8'h00;
    phy_rx_dv = 1'h0;
    phy_rx_er = 1'h0;
    phy_col = 1'h0;
    phy_crs = 1'h0;
  end
  // released line is pulled high
  assign mdio_i = (mdio_t === 1'h0) ? mdio_o : rd_bit;
  always #200 phy_tx_clk = ~phy_tx_clk;
  always @(negedge mdio_t) n_rise = 0;
  always @(posedge mdc) n_rise++;
  // turnaround zero, then read data msb first
  always @(negedge mdc) rd_bit = (n_rise == 47) ? 1'h0 :
    (n_rise > 47 && n_rise < 64) ? RD_VAL[63 - n_rise] : 1'h1;
  // one rx clock: low nibble on rise, high nibble on fall
  task automatic rx_cyc(input logic [3:0] lo, hi, input logic cr, cf);
    phy_rxd <= {4'h0, lo};
    phy_rx_dv <= cr;
    repeat (4) @(posedge clk);
    phy_rx_clk <= 1'h1;
    repeat (4) @(posedge clk);
    phy_rxd <= {4'h0, hi};
    phy_rx_dv <= cf;
    repeat (4) @(posedge clk);
    phy_rx_clk <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic set_cc(input logic c, s);
    phy_col <= c;
    phy_crs <= s;
  endtask
endmodule
`default_nettype wire

// [verif/tsm_sideband_tb.sv]
`default_nettype none
module tsm_sideband_tb
  import tsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 1000;
  localparam int TMR = 500;
  localparam logic [15:0] RDV = 16'hC3A5;
  typedef struct packed {
    logic cr;
    logic cf;
    logic [3:0] lo;
    logic [3:0] hi;
    logic v;
    logic [8:0] eb;
    logic [3:0] ib;
  } tsm_row_t;
  logic clk = 0, rst = 1, glbl_rst_n = 0, tx_valid = 0, tx_err = 0, tx_ready;
  logic [1:0] speed_sel = SPD_1G, inband_speed;
  logic [7:0] tx_data = 8'h00, rx_data, phy_txd, phy_rxd;
  logic rx_valid, rx_err, phy_tx_en, phy_tx_er, phy_txc, phy_tx_clk, phy_rx_clk;
  logic phy_rx_dv, phy_rx_er, phy_col, phy_crs, col, crs, inband_link, inband_duplex;
  logic shared_tx_clock, shared_tx_clock_quarter_phase, mgmt_start = 0, mgmt_read = 0;
  logic [4:0] mgmt_phy = 5'h13, mgmt_reg = 5'h0A;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata;
  logic [5:0] mgmt_div = 6'h03;
  logic mgmt_busy, mgmt_done, mdc, mdio_i, mdio_o, mdio_t, int_enable = 0, int_clear = 0;
  logic mac_int, ptp_rx_event = 0, ptp_tx_event = 0, ptp_rx_int, ptp_tx_int, ptp_timer_int;
  logic [29:0] rtc_nanosec;
  logic [47:0] rtc_sec;
  logic [31:0] rtc_nanosec_1722;
  logic class_interval_clock, lo_ok = 0;
  logic [3:0] lo_n;
  logic [63:0] frm;
  logic [8:0] rxq[$], txq[$];
  logic [8:0] txe[3] = '{9'h0A5, 9'h13C, 9'h00F};
  tsm_row_t rows[6];
  int n_mismatch = 0, checks_done = 0;

  tsm_sideband #(.SEC_NS(30'h3E8), .TIMER_NS(23'h1F4)) i_tsm_sideband (
    .clk, .rst, .glbl_rst_n, .speed_sel, .tx_data, .tx_valid, .tx_err, .tx_ready,
    .rx_data, .rx_valid, .rx_err, .phy_txd, .phy_tx_en, .phy_tx_er, .phy_txc,
    .phy_tx_clk, .phy_rx_clk, .phy_rxd, .phy_rx_dv, .phy_rx_er, .phy_col, .phy_crs,
    .col, .crs, .inband_link, .inband_speed, .inband_duplex, .shared_tx_clock,
    .shared_tx_clock_quarter_phase, .mgmt_start, .mgmt_read, .mgmt_phy, .mgmt_reg,
    .mgmt_wdata, .mgmt_div, .mgmt_rdata, .mgmt_busy, .mgmt_done, .mdc, .mdio_i,
    .mdio_o, .mdio_t, .int_enable, .int_clear, .mac_int, .ptp_rx_event, .ptp_tx_event,
    .ptp_rx_int, .ptp_tx_int, .ptp_timer_int, .rtc_nanosec, .rtc_sec,
    .rtc_nanosec_1722, .class_interval_clock
  );
  tsm_phy_model #(.RD_VAL(RDV)) i_tsm_phy_model (
    .clk, .mdc, .mdio_o, .mdio_t, .mdio_i, .phy_tx_clk, .phy_rx_clk, .phy_rxd,
    .phy_rx_dv, .phy_rx_er, .phy_col, .phy_crs
  );

  always #25 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'h1) rxq.push_back({rx_err, rx_data});
  always @(posedge mdc) if (mdio_t === 1'h0) frm <= {frm[62:0], mdio_o};
  // pair tx nibbles: ctl low in second half flags an error
  always @(posedge clk) begin
    if (phy_txc === 1'h1 && phy_tx_en === 1'h1) begin
      lo_n <= phy_txd[3:0];
      lo_ok <= !phy_tx_er;
    end else if (phy_txc === 1'h0 && lo_ok) begin
      txq.push_back({!phy_tx_en, phy_txd[3:0], lo_n});
      lo_ok <= 1'h0;
    end
  end

  task automatic chk(input logic [63:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tx_send(input logic [8:0] eb);
    tx_data <= eb[7:0];
    tx_err <= eb[8];
    tx_valid <= 1'h1;
    repeat (40) begin
      @(negedge clk);
      if (tx_ready === 1'h1) break;
    end
    @(posedge clk);
  endtask
  task automatic md(input logic r, input logic [15:0] w, output int n);
    @(posedge clk);
    mgmt_read <= r;
    mgmt_wdata <= w;
    mgmt_start <= 1'h1;
    @(posedge clk);
    mgmt_start <= 1'h0;
    n = 0;
    while (mgmt_done !== 1'h1 && n < 2000) begin
      @(negedge clk);
      n++;
      if (n == 1) chk(64'(mgmt_busy), 64'h1, "busy");
    end
    chk(64'(n >= 128 * (mgmt_div + 1) && n <= 128 * (mgmt_div + 1) + 4), 64'h1, "mdc");
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, pn, tc, cc;
    logic [47:0] ps;
    logic [31:0] pq;
    logic sh1, sh2, pc, ts, cs;
    rows = '{'{1'h0, 1'h0, 4'hD, 4'hD, 1'h0, 9'h000, 4'hD},
             '{1'h0, 1'h0, 4'h2, 4'h2, 1'h0, 9'h000, 4'h2},
             '{1'h1, 1'h1, 4'h5, 4'hA, 1'h1, 9'h0A5, 4'h2},
             '{1'h1, 1'h0, 4'hC, 4'h3, 1'h1, 9'h13C, 4'h2},
             '{1'h1, 1'h1, 4'hF, 4'h0, 1'h1, 9'h00F, 4'h2},
             '{1'h0, 1'h0, 4'hB, 4'hB, 1'h0, 9'h000, 4'hB}};
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    glbl_rst_n <= 1'h1;
    @(negedge clk);
    chk(64'({tx_ready, mgmt_busy, mac_int, mdio_t, mdio_o}), 64'h3, "reset");
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      i_tsm_phy_model.rx_cyc(rows[i].lo, rows[i].hi, rows[i].cr, rows[i].cf);
      repeat (6) @(posedge clk);
      chk(64'(rxq.size()), 64'(rows[i].v), "rx count");
      if (rxq.size() > 0) chk(64'(rxq.pop_front()), 64'(rows[i].eb), "rx byte");
      chk(64'({inband_duplex, inband_speed, inband_link}), 64'(rows[i].ib), "inband");
    end
    foreach (txe[i]) tx_send(txe[i]);
    tx_valid <= 1'h0;
    repeat (10) @(posedge clk);
    chk(64'(txq.size()), 64'h3, "tx count");
    foreach (txe[i]) if (txq.size() > 0) chk(64'(txq.pop_front()), 64'(txe[i]), "tx");
    speed_sel <= SPD_10;
    tx_send(txe[1]);
    tx_valid <= 1'h0;
    repeat (20) @(posedge clk);
    chk(64'(txq.size()), 64'h1, "tx 10m count");
    if (txq.size() > 0) chk(64'(txq.pop_front()), 64'(txe[1]), "tx 10m");
    int_enable <= 1'h1;
    md(1'h0, 16'h5A3C, n);
    chk(frm, {MD_PRE, MD_SOF, MD_OP_WR, mgmt_phy, mgmt_reg, MD_TA_WR, mgmt_wdata}, "wr");
    repeat (6) @(negedge clk);
    chk(64'(mac_int), 64'h1, "int set");
    @(posedge clk) int_clear <= 1'h1;
    @(posedge clk) int_clear <= 1'h0;
    int_enable <= 1'h0;
    @(negedge clk) chk(64'(mac_int), 64'h0, "int clear");
    md(1'h1, 16'h0000, n);
    chk(64'(mgmt_rdata), 64'(RDV), "rd data");
    chk(64'(frm[13:0]), 64'({MD_SOF, MD_OP_RD, mgmt_phy, mgmt_reg}), "rd hdr");
    repeat (3) @(negedge clk);
    chk(64'(mac_int), 64'h0, "int masked");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) {ptp_tx_event, ptp_rx_event} <= 2'(1 << i);
      @(posedge clk) {ptp_tx_event, ptp_rx_event} <= 2'h0;
      @(negedge clk) chk(64'({ptp_tx_int, ptp_rx_int}), 64'(1 << i), "ptp");
      @(negedge clk) chk(64'({ptp_tx_int, ptp_rx_int}), 64'h0, "ptp end");
    end
    for (int i = 1; i < 3; i++) begin
      @(posedge clk) i_tsm_phy_model.set_cc(i[1], i[0]);
      repeat (2) @(posedge clk);
      @(negedge clk) chk(64'({col, crs}), 64'(i - 1), "cc early");
      @(negedge clk) chk(64'({col, crs}), 64'(i), "cc");
    end
    @(negedge clk) sh1 = shared_tx_clock;
    @(negedge clk) {tc, cc, ts, cs} = '0;
    pn = int'(rtc_nanosec);
    ps = rtc_sec;
    pq = rtc_nanosec_1722;
    repeat (2600) begin
      sh2 = sh1;
      sh1 = shared_tx_clock;
      pc = class_interval_clock;
      @(negedge clk);
      tc++;
      cc++;
      chk(64'(rtc_nanosec), 64'((pn + 50) % SEC), "ns");
      chk(64'(rtc_sec), 64'(ps) + 64'(pn + 50 >= SEC), "sec");
      chk(64'(rtc_nanosec_1722), 64'(pq) + 64'h32, "ns 1722");
      chk(64'(shared_tx_clock_quarter_phase), 64'(sh1), "quarter");
      chk(64'(shared_tx_clock), 64'(!sh2), "shared");
      if (ptp_timer_int === 1'h1) begin
        if (ts) chk(64'(tc), 64'(TMR / CLK_NS), "timer");
        ts = 1'h1;
        tc = 0;
      end
      if (class_interval_clock !== pc) begin
        if (cs) chk(64'(cc), 64'(CLASS_CYC), "class");
        cs = 1'h1;
        cc = 0;
      end
      pn = int'(rtc_nanosec);
      ps = rtc_sec;
      pq = rtc_nanosec_1722;
    end
    @(posedge clk) glbl_rst_n <= 1'h0;
    @(negedge clk) chk(64'({rtc_nanosec, mdio_t, mdio_o}), 64'h3, "async");
    repeat (2) @(posedge clk);
    glbl_rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk) chk(64'(rtc_nanosec), 64'h32, "restart");
    stop_test();
  end
endmodule
`default_nettype wire
